// File: src/sgc_port.sv
// Serial gain-control port: three-wire load of a gain word, saturating decode.
// Assumes link pins are asynchronous to clk_i and sampled here; bus is AXI4-Lite.
// Operation
// R1 - Falling load window starts a load; serial bits then accepted on clock edges.
// R2 - While window low, each serial clock rise shifts one bit in, MSB first.
// R3 - Eighth rise of an 8-bit word pushes the MSB out and drops it.
// R4 - Rising window copies the seven shifted bits into the gain latch; the code skips the copy while the freeze bit is set.
// R5 - While window low, the latched gain word stays unchanged.
// R6 - After window rises, serial clock edges are ignored until it falls again.
// R7 - Host gives eight serial clocks with the whole word before raising window.
// R8 - Gain setting comes from the latch, never from the shift register.
// R9 - Decoded gain rises one step per code from 0 to 71.
// R10 - Latched codes 71 through 127 all decode to the maximum 71.
// R11 - Top bit of the word is ignored, so code 128 decodes as 0.
// R12 - Code 0 is minimum gain; each code step adds one fixed gain step.
// R13 - Power-down input high enables forward amplifier in transmit mode.
// R14 - Power-down input low disables forward amp and output, enables reverse amp.
// R15 - Clock rise captures bit into master; following fall moves it to slave.
// R16 - Beyond eight clocks, the latch gets the last seven bits shifted in.
// R17 - Gain latch starts at code 0 so start-up attenuation is known.
module sgc_port
    import sgc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Serial link pins
    input  wire logic        serial_clk_i,
    input  wire logic        serial_gain_in_i,
    input  wire logic        load_window_n_i,
    input  wire logic        amp_sleep_n_i,
    // Amplifier control
    output logic [6:0]       gain_step_o,
    output logic             fwd_amp_en_o,
    output logic             out_en_o,
    output logic             rev_amp_en_o,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Two flops per pin; logic reads stage two, and edge detection also reads a third delayed copy
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] pins_d;
    always_ff @(posedge clk_i) begin
        sync1  <= {amp_sleep_n_i, load_window_n_i, serial_gain_in_i, serial_clk_i};
        sync2  <= sync1;
        pins_d <= sync2;
    end

    logic sclk;
    logic sdat;
    logic win_n;
    logic sleep_n;
    logic sclk_rise;
    logic sclk_fall;
    logic win_fall;
    logic win_rise;
    assign sclk      = sync2[0];
    assign sdat      = sync2[1];
    assign win_n     = sync2[2];
    assign sleep_n   = sync2[3];
    assign sclk_rise = sclk & ~pins_d[0];
    assign sclk_fall = ~sclk & pins_d[0];
    assign win_fall  = ~win_n & pins_d[2];
    assign win_rise  = win_n & ~pins_d[2];

    // ****************************************************************
    // Load window state, shift register and gain latch
    // ****************************************************************
    sgc_state_t       state;
    sgc_state_t       next_state;
    logic [6:0]       slave_sr;
    logic [6:0]       next_slave_sr;
    logic             master_bit;
    logic             next_master_bit;
    logic             master_full;
    logic             next_master_full;
    logic [6:0]       gain_latch;
    logic [6:0]       next_gain_latch;
    logic [3:0]       edge_cnt;
    logic [3:0]       next_edge_cnt;
    logic             freeze;
    logic [6:0]       captured;

    // A rise still in the master stage is folded in if the window closes first
    assign captured = master_full ? {slave_sr[5:0], master_bit} : slave_sr;

    // Next-state logic for the serial load
    always_comb begin
        next_state       = state;
        next_slave_sr    = slave_sr;
        next_master_bit  = master_bit;
        next_master_full = master_full;
        next_gain_latch  = gain_latch;
        next_edge_cnt    = edge_cnt;
        case (state)
            SGC_IDLE: begin
                // Serial clock edges are ignored here [R6]
                if (win_fall) begin                          // [R1]
                    next_state       = SGC_SHIFT;
                    next_edge_cnt    = 4'h0;
                    next_master_full = 1'b0;
                end
            end
            SGC_SHIFT: begin
                if (win_rise) begin
                    // Latch update only on closing the window [R4] [R5] [R16]
                    if (!freeze) begin
                        next_gain_latch = captured;
                    end
                    next_state       = SGC_IDLE;            // [R6]
                    next_master_full = 1'b0;
                end else if (sclk_rise) begin
                    next_master_bit  = sdat;                 // [R15] [R2]
                    next_master_full = 1'b1;
                    if (edge_cnt != SGC_CNT_SAT) begin
                        next_edge_cnt = edge_cnt + 4'h1;
                    end
                end else if (sclk_fall && master_full) begin
                    // Oldest bit leaves the top and is lost [R3] [R16]
                    next_slave_sr    = {slave_sr[5:0], master_bit};   // [R15]
                    next_master_full = 1'b0;
                end
            end
            default: begin
                next_state = SGC_IDLE;
            end
        endcase
    end

    // Registers of the serial load; latch starts at minimum gain
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state       <= SGC_IDLE;
            slave_sr    <= SGC_CODE_RESET;
            master_bit  <= 1'b0;
            master_full <= 1'b0;
            gain_latch  <= SGC_CODE_RESET;                   // [R17]
            edge_cnt    <= 4'h0;
        end else begin
            state       <= next_state;
            slave_sr    <= next_slave_sr;
            master_bit  <= next_master_bit;
            master_full <= next_master_full;
            gain_latch  <= next_gain_latch;
            edge_cnt    <= next_edge_cnt;
        end
    end

    // ****************************************************************
    // Gain decode and amplifier mode
    // ****************************************************************
    // Saturating decode from the latch only; the latch holds 7 bits, so the
    // discarded word MSB cannot reach it [R8] [R9] [R10] [R11] [R12]
    logic [6:0] next_gain_step;
    logic       next_fwd;
    always_comb begin
        next_gain_step = (gain_latch > SGC_CODE_MAX) ? SGC_CODE_MAX : gain_latch;
        next_fwd       = sleep_n;                            // [R13] [R14]
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            gain_step_o  <= SGC_CODE_RESET;
            fwd_amp_en_o <= 1'b0;
            out_en_o     <= 1'b0;
            rev_amp_en_o <= 1'b1;
        end else begin
            gain_step_o  <= next_gain_step;
            fwd_amp_en_o <= next_fwd;                        // [R13]
            out_en_o     <= next_fwd;                        // [R14]
            rev_amp_en_o <= ~next_fwd;                       // [R14]
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    // Address and data are held until both arrived, then answered together
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic [31:0] rd_word;
    logic        rd_ok;

    assign do_write = aw_held & w_held & ~s_axi_bvalid;

    // Read mux; unmapped offsets answer SLVERR with zero data
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok   = 1'b1;
        case (s_axi_araddr)
            SGC_ADDR_STATUS: begin
                rd_word[6:0]                         = gain_latch;
                rd_word[SGC_ST_CNT_LSB +: 4]         = edge_cnt;
                rd_word[SGC_ST_LOADING]              = (state == SGC_SHIFT);
                rd_word[SGC_ST_TX]                   = sleep_n;
            end
            SGC_ADDR_SHIFT: rd_word[6:0] = slave_sr;
            SGC_ADDR_CTRL:  rd_word[SGC_CTRL_FREEZE] = freeze;
            default:        rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            freeze        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= SGC_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= SGC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= SGC_RESP_OKAY;
                if (aw_addr == SGC_ADDR_CTRL) begin
                    if (w_strb[0]) begin
                        freeze <= w_data[SGC_CTRL_FREEZE];
                    end
                end else if (aw_addr != SGC_ADDR_STATUS && aw_addr != SGC_ADDR_SHIFT) begin
                    s_axi_bresp <= SGC_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_ok ? SGC_RESP_OKAY : SGC_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // The closing edge itself is excluded: that is where the latch loads
    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [R5]
        (state == SGC_SHIFT && !win_rise) |=> $stable(gain_latch))
        else $error("gain latch changed inside load window");
    AST_LATCH_LOAD: assert property (@(posedge clk_i) disable iff (reset_i) // [R4]
        (state == SGC_SHIFT && win_rise && !freeze) |=> (gain_latch == $past(captured)))
        else $error("gain latch missed shift contents");
    AST_IDLE_IGNORE: assert property (@(posedge clk_i) disable iff (reset_i) // [R6]
        (state == SGC_IDLE && !win_fall) |=> $stable(slave_sr) && !master_full)
        else $error("shift register moved outside load window");
    AST_START: assert property (@(posedge clk_i) disable iff (reset_i) // [R1]
        (state == SGC_IDLE && win_fall) |=> (state == SGC_SHIFT))
        else $error("load did not start on falling window");
    AST_SHIFT_IN: assert property (@(posedge clk_i) disable iff (reset_i) // [R2]
        (state == SGC_SHIFT && !win_rise && sclk_rise) |=> master_full && master_bit == $past(sdat))
        else $error("serial bit not captured on clock rise");
    AST_SLAVE: assert property (@(posedge clk_i) disable iff (reset_i) // [R15]
        (state == SGC_SHIFT && !win_rise && !sclk_rise && sclk_fall && master_full)
        |=> slave_sr == {$past(slave_sr[5:0]), $past(master_bit)})
        else $error("master bit not moved to slave on clock fall");
    AST_SATURATE: assert property (@(posedge clk_i) disable iff (reset_i) // [R10]
        (gain_latch >= SGC_CODE_MAX) |=> (gain_step_o == SGC_CODE_MAX))
        else $error("decode did not saturate at code 71");
    AST_LINEAR: assert property (@(posedge clk_i) disable iff (reset_i) // [R9]
        (gain_latch < SGC_CODE_MAX) |=> (gain_step_o == $past(gain_latch)))
        else $error("decode not linear below code 71");
    AST_MODE: assert property (@(posedge clk_i) disable iff (reset_i) // [R14]
        1'b1 |=> ##1 (rev_amp_en_o == ~fwd_amp_en_o) && (out_en_o == fwd_amp_en_o))
        else $error("amplifier mode outputs inconsistent");
    AST_FWD_FOLLOW: assert property (@(posedge clk_i) disable iff (reset_i) // [R13]
        1'b1 |=> (fwd_amp_en_o == $past(sleep_n)))
        else $error("forward amplifier does not follow power-down pin");

    COV_LOAD: cover property (@(posedge clk_i) disable iff (reset_i)
        state == SGC_SHIFT && win_rise && edge_cnt == SGC_CNT_W8);
    COV_LONG: cover property (@(posedge clk_i) disable iff (reset_i)
        state == SGC_SHIFT && win_rise && edge_cnt > SGC_CNT_W8);
    COV_SAT: cover property (@(posedge clk_i) disable iff (reset_i)
        gain_latch > SGC_CODE_MAX);
    COV_SLEEP: cover property (@(posedge clk_i) disable iff (reset_i) $fell(sleep_n));

endmodule

// File: src/sgc_pkg.sv
// Package for the serial gain-control port: widths, codes and register map.
// Assumes a single 250 MHz system clock and an AXI4-Lite register bus.
package sgc_pkg;

    // ****************************************************************
    // Serial word and gain code layout
    // ****************************************************************
    localparam int          SGC_SHIFT_W    = 7;
    localparam int          SGC_WORD_BITS  = 8;
    localparam logic [6:0]  SGC_CODE_MAX   = 7'h47;   // Code 71, full gain
    localparam logic [6:0]  SGC_CODE_RESET = 7'h00;   // Minimum gain at start
    localparam logic [3:0]  SGC_CNT_W8     = 4'h8;
    localparam logic [3:0]  SGC_CNT_SAT    = 4'hF;

    // ****************************************************************
    // Register map (byte addresses) and field positions
    // ****************************************************************
    localparam logic [7:0]  SGC_ADDR_STATUS = 8'h00;
    localparam logic [7:0]  SGC_ADDR_SHIFT  = 8'h04;
    localparam logic [7:0]  SGC_ADDR_CTRL   = 8'h08;
    localparam int          SGC_ST_LOADING  = 16;
    localparam int          SGC_ST_TX       = 17;
    localparam int          SGC_ST_CNT_LSB  = 8;
    localparam int          SGC_CTRL_FREEZE = 0;
    localparam logic [1:0]  SGC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SGC_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Load window states
    // ****************************************************************
    typedef enum logic [1:0] {
        SGC_IDLE  = 2'b01,
        SGC_SHIFT = 2'b10
    } sgc_state_t;

endpackage

// File: tb/sgc_host.sv
// Host controller model driving the three serial wires of the gain port.
// Assumes clk_i is the 250 MHz clock; 40 of its cycles make one 160 ns serial clock.
module sgc_host (
    // Clock
    input  wire logic clk_i,
    // Serial link pins
    output logic      serial_clk_o,
    output logic      serial_gain_o,
    output logic      load_window_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Frame tasks
    // ****************************************************************
    // Idle: window high, serial clock parked low
    initial begin
        serial_clk_o    = 1'b0;
        serial_gain_o   = 1'b0;
        load_window_n_o = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Falling window starts a load
    task automatic open_window();
        wait_clk(8);
        load_window_n_o <= 1'b0;
        wait_clk(10);
    endtask

    // Bits go MSB first, data settled 10 cycles before each rise
    task automatic send_bits(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_gain_o <= w[i];
            wait_clk(10);
            serial_clk_o <= 1'b1;
            wait_clk(20);
            serial_clk_o <= 1'b0;
            wait_clk(10);
        end
        // Released line flips so a stale bit cannot pass for data
        serial_gain_o <= ~serial_gain_o;
    endtask

    // Window back high only after the word is complete
    task automatic close_window();
        load_window_n_o <= 1'b1;
        wait_clk(10);
    endtask
endmodule

// File: tb/test_serial_gain_control_port.sv
// Self-checking bench for the serial gain port: host model plus AXI4-Lite master.
// Assumes sgc_pkg is compiled first; a queue model predicts latch and gain.
module test_serial_gain_control_port import sgc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic        clk_i = 1'b0, reset_i = 1'b1, amp_sleep_n_i = 1'b0;
    logic        serial_clk_i, serial_gain_in_i, load_window_n_i;
    logic [6:0]  gain_step_o;
    logic        fwd_amp_en_o, out_en_o, rev_amp_en_o;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    bit          q[$];
    int          latch = 0, n_mismatch = 0, n_checks = 0;
    bit          frz = 1'b0;

    always #2 clk_i = ~clk_i;

    sgc_port dut (.clk_i, .reset_i, .serial_clk_i, .serial_gain_in_i, .load_window_n_i,
        .amp_sleep_n_i, .gain_step_o, .fwd_amp_en_o, .out_en_o, .rev_amp_en_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    sgc_host host (.clk_i, .serial_clk_o(serial_clk_i), .serial_gain_o(serial_gain_in_i),
        .load_window_n_o(load_window_n_i));

    // ****************************************************************
    // Model, checks and bus tasks
    // ****************************************************************
    // Seven newest bits form the shift register; older ones fall off
    function automatic int shreg();
        int v = 0;
        foreach (q[i]) v = (v << 1) | int'(q[i]);
        return v & 127;
    endfunction
    function automatic logic [6:0] exp_gain();
        return (latch > 71) ? 7'h47 : 7'(latch);
    endfunction

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    // Short bounded settle: the output lags the pins by a few cycles
    task automatic chk_gain(input logic [6:0] exp);
        n_checks++;
        for (int i = 0; i < 40 && gain_step_o !== exp; i++) @(posedge clk_i);
        if (gain_step_o !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: gain %h, expected %h", $time, gain_step_o, exp);
        end
    endtask
    task automatic chk_amp(input logic s);
        repeat (8) @(posedge clk_i);
        chk_word({29'h0, fwd_amp_en_o, out_en_o, rev_amp_en_o}, {29'h0, s, s, ~s});
    endtask
    task automatic hang();
        n_mismatch++;
        $display("mismatch at %0t: bus wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 50) hang();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 50) hang();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic push(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) q.push_back(w[i]);
        while (q.size() > 7) void'(q.pop_front());
    endtask
    // Whole load: gain must hold while the window is low, then follow the latch
    task automatic load(input logic [15:0] w, input int n);
        host.open_window();
        host.send_bits(w, n);
        push(w, n);
        chk_gain(exp_gain());
        host.close_window();
        if (!frz) latch = shreg();
        chk_gain(exp_gain());
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [15:0] codes [10];
        void'($urandom(32'hD974));
        codes = '{16'h0, 16'h1, 16'h46, 16'h47, 16'h48, 16'h7F,
                  16'h80, 16'hC7, 16'hC8, 16'hFF};
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        chk_gain(7'h00);
        chk_amp(1'b0);
        amp_sleep_n_i <= 1'b1;
        chk_amp(1'b1);
        amp_sleep_n_i <= 1'b0;
        chk_amp(1'b0);
        amp_sleep_n_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        // Boundary codes then random ones; raw latch read beside saturated gain
        for (int k = 0; k < 14; k++) begin
            load((k < 10) ? codes[k] : 16'($urandom_range(0, 255)), 8);
            axi_rd(SGC_ADDR_STATUS, d, r);
            // Rise count of the last window (8) stays visible after it closes
            chk_word(d, 32'h20800 | 32'(latch));
        end
        load(16'h2D5, 10);
        // Partial frame: count, shift contents and untouched latch mid-window
        host.open_window();
        host.send_bits(16'h5, 3);
        push(16'h5, 3);
        axi_rd(SGC_ADDR_STATUS, d, r);
        chk_word(d, 32'h30300 | 32'(latch));
        axi_rd(SGC_ADDR_SHIFT, d, r);
        chk_word(d, 32'(shreg()));
        host.send_bits(16'h1A, 5);
        push(16'h1A, 5);
        host.close_window();
        latch = shreg();
        chk_gain(exp_gain());
        // Serial clocks with the window high must leave everything alone
        host.send_bits(16'hA5, 8);
        axi_rd(SGC_ADDR_SHIFT, d, r);
        chk_word(d, 32'(shreg()));
        chk_gain(exp_gain());
        // Freeze blocks the latch update; control reads back
        axi_wr(SGC_ADDR_CTRL, 32'h1, r);
        chk_word(32'(r), 32'(SGC_RESP_OKAY));
        frz = 1'b1;
        load(16'h33, 8);
        axi_rd(SGC_ADDR_CTRL, d, r);
        chk_word(d, 32'h1);
        axi_wr(SGC_ADDR_CTRL, 32'h0, r);
        frz = 1'b0;
        load(16'h33, 8);
        // Unmapped place answers with an error and zero data
        axi_rd(8'h0C, d, r);
        chk_word({d[29:0], r}, {30'h0, SGC_RESP_SLVERR});
        axi_wr(SGC_ADDR_STATUS, 32'hFF, r);
        chk_word(32'(r), 32'(SGC_RESP_OKAY));
        tally_and_finish();
    end
endmodule
